// ==== pkg/tcs_pkg.sv ====
`default_nettype none
package tcs_pkg;
  // clock and slot time
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLOT_TIME_NS  = 51200;
  // a late collision is one seen at or after this many cycles past tx start
  localparam int SLOT_CYCLES   = (SLOT_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int SLOT_W        = 10;

  // management addressing
  localparam logic [9:0] STAT_PAGE = 10'h30A;  // page 778
  localparam logic [9:0] CFG_PAGE  = 10'h301;  // page 769
  localparam logic [4:0] CFG_REG   = 5'h15;    // register 21

  // statistics counters and their first (upper-half) register numbers
  localparam int NUM_STATS = 7;
  typedef enum logic [2:0] {
    TCS_SINGLE, TCS_EXCESS, TCS_MULTI, TCS_LATE,
    TCS_TOTAL, TCS_DEFER, TCS_NOCRS
  } tcs_stat_t;
  localparam logic [4:0] STAT_BASE [NUM_STATS] = '{
    5'h10, 5'h12, 5'h14, 5'h17, 5'h19, 5'h1B, 5'h1D
  };
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;

  // collision threshold register fields
  localparam int           THR_LSB     = 1;
  localparam int           THR_MSB     = 8;
  localparam int           RETRY_BIT   = 0;
  localparam logic [7:0]   THR_RESET   = 8'h0F;
  localparam logic         RETRY_RESET = 1'b0;
  localparam logic [7:0]   EXCESS_LIM  = 8'h10;  // 16 collisions
  localparam logic [4:0]   COLL_LIM    = 5'h10;
endpackage : tcs_pkg
`default_nettype wire

// ==== rtl/tcs_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcs_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // event
  input  wire logic        inc,
  // count
  output logic [31:0]      count_reg
);
  import tcs_pkg::*;

  // wraps from all ones to zero; reads never touch it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= STAT_RESET;
    end else if (inc) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end
endmodule : tcs_counter
`default_nettype wire

// ==== rtl/tcs_slot_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcs_slot_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // transmit enable toward the transceiver
  input  wire logic        tx_en,
  // slot status
  output logic             slot_over_reg
);
  import tcs_pkg::*;

  logic [SLOT_W-1:0] cnt_reg;
  logic              tx_en_d_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_en_d_reg <= 1'b0;
    end else begin
      tx_en_d_reg <= tx_en;
    end
  end

  // counts cycles from the tx_en rise; saturates once the slot is over
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg       <= '0;
      slot_over_reg <= 1'b0;
    end else if (tx_en && !tx_en_d_reg) begin
      cnt_reg       <= SLOT_W'(1);
      slot_over_reg <= 1'b0;
    end else if (tx_en && !slot_over_reg) begin
      cnt_reg       <= cnt_reg + SLOT_W'(1);
      slot_over_reg <= (cnt_reg >= SLOT_W'(SLOT_CYCLES - 1));
    end
  end
endmodule : tcs_slot_timer
`default_nettype wire

// ==== rtl/tcs_stats.sv ====
// Notes on behaviour
// - each counter reads as two halves; upper half at lower register number
// - all counters are read-only 32-bit, hardware-updated, reset to zero
// - single count rises for a good transmit with exactly one collision
// - collision counters move only when transmit enabled and half duplex
// - excessive count rises once a packet reaches 16 collisions
// - with threshold below 16 the excessive count never rises
// - multiple count rises for a transmit with 2 to 15 collisions
// - late count rises for packets colliding after one slot time
// - total count adds every collision, clear or secure traffic
// - defer count rises when a packet cannot start at once
// - defer gated by transmit enable only; not for streaming gap waits
// - no-carrier count rises when carrier missing within one slot
// - transmission start is the cycle tx_en rises
// - no-carrier count gated by transmit enable; meaningful in half duplex
// - collision threshold is 8 bits, default 0x0F, retry count
`timescale 1ns/1ns
`default_nettype none
module tcs_stats (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // transmit path status
  input  wire logic        tx_enable,
  input  wire logic        half_duplex,
  input  wire logic        tx_en,
  input  wire logic        crs,
  input  wire logic        collision,
  input  wire logic        tx_done,
  input  wire logic        tx_ok,
  input  wire logic        defer_event,
  input  wire logic        defer_ipg_stream,
  // management register access
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [9:0]  mgmt_page,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_rvalid,
  // configuration out
  output logic [7:0]       coll_threshold,
  output logic             retry_late_coll
);
  import tcs_pkg::*;

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic [7:0] thr_reg;
  logic       retry_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thr_reg   <= THR_RESET;
      retry_reg <= RETRY_RESET;
    end else if (mgmt_wr && mgmt_page == CFG_PAGE
                 && mgmt_addr == CFG_REG) begin
      thr_reg   <= mgmt_wdata[THR_MSB:THR_LSB];
      retry_reg <= mgmt_wdata[RETRY_BIT];
    end
  end

  assign coll_threshold  = thr_reg;
  assign retry_late_coll = retry_reg;

  // ---------------------------------------------------------------
  // per-transmission tracking
  // ---------------------------------------------------------------
  logic       slot_over;
  logic       tx_en_d_reg;
  logic       tx_start;
  logic [4:0] coll_cnt_reg;
  logic       late_reg;
  logic       crs_seen_reg;
  logic       hd_gate;

  tcs_slot_timer u_slot (
    .clk           (clk),
    .reset_n       (reset_n),
    .tx_en         (tx_en),
    .slot_over_reg (slot_over)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_en_d_reg <= 1'b0;
    end else begin
      tx_en_d_reg <= tx_en;
    end
  end

  assign tx_start = tx_en && !tx_en_d_reg;
  assign hd_gate  = tx_enable && half_duplex;

  // collision count per packet, saturating at 16; a new start reloads it with 1 or 0 from that cycle's collision
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coll_cnt_reg <= '0;
    end else if (tx_start) begin
      coll_cnt_reg <= collision ? 5'h01 : 5'h00;
    end else if (tx_done) begin
      coll_cnt_reg <= '0;
    end else if (collision && coll_cnt_reg != COLL_LIM) begin
      coll_cnt_reg <= coll_cnt_reg + 5'h01;
    end
  end

  // late flag: a collision once the slot has run out
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      late_reg <= 1'b0;
    end else if (tx_start || tx_done) begin
      late_reg <= 1'b0;
    end else if (collision && slot_over) begin
      late_reg <= 1'b1;
    end
  end

  // carrier seen inside the first slot of the transmission
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crs_seen_reg <= 1'b0;
    end else if (tx_start) begin
      crs_seen_reg <= crs;
    end else if (tx_done) begin
      crs_seen_reg <= 1'b0;
    end else if (crs && !slot_over) begin
      crs_seen_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // increment conditions
  // ---------------------------------------------------------------
  logic [NUM_STATS-1:0] inc;
  logic                 excess_ok;

  // with fewer retries than 16 the packet is dropped before the limit
  assign excess_ok = (thr_reg >= EXCESS_LIM);

  always_comb begin
    inc = '0;
    inc[TCS_SINGLE] = hd_gate && tx_done && tx_ok
                      && coll_cnt_reg == 5'h01;
    inc[TCS_MULTI]  = hd_gate && tx_done && tx_ok
                      && coll_cnt_reg > 5'h01
                      && coll_cnt_reg < COLL_LIM;
    inc[TCS_EXCESS] = hd_gate && tx_done && excess_ok
                      && coll_cnt_reg == COLL_LIM;
    inc[TCS_LATE]   = hd_gate && tx_done && late_reg;
    inc[TCS_TOTAL]  = hd_gate && collision;
    inc[TCS_DEFER]  = tx_enable && defer_event
                      && !defer_ipg_stream;
    // relies on the transceiver raising carrier on every transmit
    inc[TCS_NOCRS]  = tx_enable && tx_done && tx_ok
                      && !crs_seen_reg;
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [31:0] cnt [NUM_STATS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STATS; gi++) begin : g_cnt
      tcs_counter u_cnt (
        .clk       (clk),
        .reset_n   (reset_n),
        .inc       (inc[gi]),
        .count_reg (cnt[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [15:0] rdata_next;

  // reads are pure muxes, so a read never disturbs a counter
  always_comb begin
    rdata_next = 16'h0000;
    if (mgmt_page == CFG_PAGE && mgmt_addr == CFG_REG) begin
      rdata_next = {7'h00, thr_reg, retry_reg};
    end else if (mgmt_page == STAT_PAGE) begin
      for (int i = 0; i < NUM_STATS; i++) begin
        if (mgmt_addr == STAT_BASE[i]) begin
          rdata_next = cnt[i][31:16];
        end else if (mgmt_addr == STAT_BASE[i] + 5'h01) begin
          rdata_next = cnt[i][15:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= rdata_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_single_end;
    tx_done && tx_ok && hd_gate && coll_cnt_reg == 5'h01;
  endsequence

  single_count_a: assert property (
    s_single_end |=> cnt[TCS_SINGLE] == $past(cnt[TCS_SINGLE]) + 32'h1)
    else $error("single count did not step");

  duplex_gate_a: assert property (
    !half_duplex && !$past(half_duplex) |=>
      $stable(cnt[TCS_TOTAL]) && $stable(cnt[TCS_MULTI]))
    else $error("collision count moved in full duplex");

  excess_thr_a: assert property (
    thr_reg < EXCESS_LIM |=> $stable(cnt[TCS_EXCESS]))
    else $error("excessive count moved with low threshold");

  excess_count_a: assert property (
    tx_done && hd_gate && excess_ok && coll_cnt_reg == COLL_LIM
    |=> cnt[TCS_EXCESS] == $past(cnt[TCS_EXCESS]) + 32'h1)
    else $error("excessive count did not step");

  sequence s_multi_end;
    tx_done && tx_ok && hd_gate
      && coll_cnt_reg >= 5'h02 && coll_cnt_reg < COLL_LIM;
  endsequence

  multi_range_a: assert property (
    s_multi_end |=> cnt[TCS_MULTI] == $past(cnt[TCS_MULTI]) + 32'h1)
    else $error("multiple count did not step");

  total_count_a: assert property (
    collision && hd_gate
    |=> cnt[TCS_TOTAL] == $past(cnt[TCS_TOTAL]) + 32'h1)
    else $error("total count missed a collision");

  defer_stream_a: assert property (
    defer_ipg_stream || !tx_enable |=> $stable(cnt[TCS_DEFER]))
    else $error("defer counted a stream gap");

  late_early_a: assert property (
    tx_start ##1 (!tx_done && !tx_start) [*8] |-> !late_reg)
    else $error("late flag set inside slot");

  nocrs_a: assert property (
    tx_start && crs ##1 (!tx_start && !tx_done) [*2] ##1 tx_done && tx_ok
    |=> $stable(cnt[TCS_NOCRS]))
    else $error("no-carrier counted with carrier");

  read_split_a: assert property (
    mgmt_rd && mgmt_page == STAT_PAGE && mgmt_addr == STAT_BASE[TCS_TOTAL]
    |=> mgmt_rvalid && mgmt_rdata == $past(cnt[TCS_TOTAL][31:16]))
    else $error("upper half read wrong");

  read_keep_a: assert property (
    mgmt_rd && !inc[TCS_DEFER] |=> $stable(cnt[TCS_DEFER]))
    else $error("read altered a counter");

  thr_reset_a: assert property (
    $rose(reset_n) |-> thr_reg == THR_RESET)
    else $error("threshold not at default");

  // end-of-packet classes, carrier and defer steps
  sequence s_late_end;
    tx_done && hd_gate && late_reg;
  endsequence

  late_count_a: assert property (
    s_late_end |=> cnt[TCS_LATE] == $past(cnt[TCS_LATE]) + 32'h1)
    else $error("late count did not step");

  sequence s_nocrs_end;
    tx_done && tx_ok && tx_enable && !crs_seen_reg;
  endsequence

  nocrs_count_a: assert property (
    s_nocrs_end |=> cnt[TCS_NOCRS] == $past(cnt[TCS_NOCRS]) + 32'h1)
    else $error("no-carrier count did not step");

  defer_count_a: assert property (
    tx_enable && defer_event && !defer_ipg_stream
    |=> cnt[TCS_DEFER] == $past(cnt[TCS_DEFER]) + 32'h1)
    else $error("defer count did not step");

  tx_off_gate_a: assert property (
    !tx_enable |=> $stable(cnt[TCS_SINGLE]) && $stable(cnt[TCS_EXCESS])
      && $stable(cnt[TCS_LATE]) && $stable(cnt[TCS_NOCRS]))
    else $error("count moved with transmit disabled");

  coll_sat_a: assert property (
    coll_cnt_reg <= COLL_LIM)
    else $error("packet collision count overran");

  class_once_a: assert property (
    $onehot0({inc[TCS_SINGLE], inc[TCS_MULTI], inc[TCS_EXCESS]}))
    else $error("packet counted in two classes");

  pkt_clear_a: assert property (
    tx_done && !tx_start |=> coll_cnt_reg == 5'h00 && !late_reg)
    else $error("packet state not cleared at end");

  read_lower_a: assert property (
    mgmt_rd && mgmt_page == STAT_PAGE
      && mgmt_addr == STAT_BASE[TCS_SINGLE] + 5'h01
    |=> mgmt_rdata == $past(cnt[TCS_SINGLE][15:0]))
    else $error("lower half read wrong");

  rdata_hold_a: assert property (
    !mgmt_rd |=> $stable(mgmt_rdata) && !mgmt_rvalid)
    else $error("read data moved without a read");

  cfg_write_a: assert property (
    mgmt_wr && mgmt_page == CFG_PAGE && mgmt_addr == CFG_REG
    |=> coll_threshold == $past(mgmt_wdata[THR_MSB:THR_LSB]))
    else $error("threshold write lost");

  cfg_keep_a: assert property (
    !mgmt_wr |=> $stable(thr_reg) && $stable(retry_reg))
    else $error("threshold changed without a write");

  // each counter steps by one or holds; the 32-bit sum wraps to zero
  for (genvar gj = 0; gj < NUM_STATS; gj++) begin : g_cnt_chk
    cnt_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      inc[gj] |=> cnt[gj] == $past(cnt[gj]) + 32'h1)
      else $error("counter missed a step");
    cnt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !inc[gj] |=> $stable(cnt[gj]))
      else $error("counter moved without an event");
  end
endmodule : tcs_stats
`default_nettype wire

// ==== verif/tcs_mac_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcs_mac_model (
  // clock
  input  wire logic clk,
  // transmit path toward the statistics block
  output logic      tx_en,
  output logic      crs,
  output logic      collision,
  output logic      tx_done,
  output logic      tx_ok
);
  initial begin
    {tx_en, crs, collision, tx_done, tx_ok} = '0;
  end
  // --------------------------------------------------------------
  // frame generation
  // --------------------------------------------------------------
  // gap keeps every collision a separate one-cycle pulse
  task automatic hit(input int gap);
    repeat (gap) @(negedge clk);
    collision = 1'b1;
    @(negedge clk);
    collision = 1'b0;
  endtask : hit
  task automatic send(input int n, input bit late, input bit cs,
                      input bit ok);
    @(negedge clk);
    tx_en = 1'b1;
    crs   = cs;
    for (int i = 0; i < n; i++) hit(2);
    if (late) hit(520);
    repeat (3) @(negedge clk);
    tx_en   = 1'b0;
    crs     = 1'b0;
    tx_done = 1'b1;
    tx_ok   = ok;
    @(negedge clk);
    tx_done = 1'b0;
    // qualifier means nothing outside tx_done, so it is left wrong here
    tx_ok   = ~ok;
  endtask : send
endmodule : tcs_mac_model
`default_nettype wire

// ==== verif/tx_collision_statistics_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tx_collision_statistics_tb_top;
  import tcs_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        tx_enable = 1'b0;
  logic        half_duplex = 1'b0;
  logic        tx_en, crs, collision, tx_done, tx_ok;
  logic        defer_event, defer_ipg_stream, mgmt_rd, mgmt_wr;
  logic [9:0]  mgmt_page;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic        mgmt_rvalid, retry_late_coll;
  logic [7:0]  coll_threshold;
  logic [7:0]  thr = THR_RESET;
  logic [31:0] exp_cnt [NUM_STATS];
  int          failures = 0;
  int          n_checks = 0;

  always #50 clk = ~clk;

  tcs_stats uut (.clk(clk), .reset_n(reset_n), .tx_enable(tx_enable),
    .half_duplex(half_duplex), .tx_en(tx_en), .crs(crs),
    .collision(collision), .tx_done(tx_done), .tx_ok(tx_ok),
    .defer_event(defer_event), .defer_ipg_stream(defer_ipg_stream),
    .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_page(mgmt_page),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .coll_threshold(coll_threshold), .retry_late_coll(retry_late_coll));
  tcs_mac_model mac (.clk(clk), .tx_en(tx_en), .crs(crs),
    .collision(collision), .tx_done(tx_done), .tx_ok(tx_ok));

  // --------------------------------------------------------------
  // checking and bus tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want,
                     input string what);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("ERROR %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic acc(input bit wr, input logic [9:0] pg,
                     input logic [4:0] ad, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(negedge clk);
    {mgmt_rd, mgmt_wr} = {~wr, wr};
    mgmt_page  = pg;
    mgmt_addr  = ad;
    mgmt_wdata = wd;
    @(negedge clk);
    // released lines move so a stale address cannot pass for a live one
    {mgmt_rd, mgmt_wr} = 2'b00;
    mgmt_page  = ~pg;
    mgmt_addr  = ~ad;
    mgmt_wdata = ~wd;
    rd = mgmt_rdata;
    chk({31'h0, mgmt_rvalid}, {31'h0, !wr}, "rvalid");
  endtask : acc
  task automatic chk_all();
    logic [15:0] h, l;
    for (int k = 0; k < NUM_STATS; k++) begin
      acc(1'b0, STAT_PAGE, STAT_BASE[k], 16'h0000, h);
      acc(1'b0, STAT_PAGE, STAT_BASE[k] + 5'h01, 16'h0000, l);
      chk({h, l}, exp_cnt[k], "counter");
    end
  endtask : chk_all
  function automatic int inc(input int k, input int n, input bit late,
                             input bit cs, input bit ok, input bit c,
                             input bit en);
    case (tcs_stat_t'(k))
      TCS_SINGLE: return int'(c && ok && n == 1);
      TCS_EXCESS: return int'(c && n >= 16 && thr >= EXCESS_LIM);
      TCS_MULTI:  return int'(c && ok && n > 1 && n < 16);
      TCS_LATE:   return int'(c && late);
      TCS_TOTAL:  return c ? n : 0;
      TCS_NOCRS:  return int'(en && ok && !cs);
      default:    return 0;
    endcase
  endfunction : inc
  task automatic frame(input int n, input bit late, input bit cs,
                       input bit ok, input bit en, input bit hd);
    @(negedge clk);
    tx_enable   = en;
    half_duplex = hd;
    mac.send(n, late, cs, ok);
    for (int k = 0; k < NUM_STATS; k++)
      exp_cnt[k] += 32'(inc(k, n + late, late, cs, ok, en && hd, en));
    repeat (2) @(negedge clk);
    chk_all();
  endtask : frame
  task automatic defer(input bit en, input bit strm);
    @(negedge clk);
    tx_enable        = en;
    half_duplex      = 1'($urandom);
    defer_event      = 1'b1;
    defer_ipg_stream = strm;
    @(negedge clk);
    defer_event      = 1'b0;
    defer_ipg_stream = ~strm;
    exp_cnt[TCS_DEFER] += 32'(en && !strm);
  endtask : defer
  task automatic set_thr(input logic [7:0] t, output logic [15:0] d);
    thr = t;
    acc(1'b1, CFG_PAGE, CFG_REG, {7'h7F, t, 1'b1}, d);
    chk({24'h0, coll_threshold}, {24'h0, t}, "threshold");
    chk({31'h0, retry_late_coll}, 32'h1, "retry");
    acc(1'b0, CFG_PAGE, CFG_REG, 16'h0000, d);
    chk({16'h0, d}, {23'h0, t, 1'b1}, "cfg read");
  endtask : set_thr
  task automatic chk_rst();
    logic [15:0] d;
    foreach (exp_cnt[k]) exp_cnt[k] = STAT_RESET;
    thr = THR_RESET;
    chk_all();
    chk({24'h0, coll_threshold}, {24'h0, THR_RESET}, "thr");
    chk({31'h0, retry_late_coll}, {31'h0, RETRY_RESET}, "retry");
    acc(1'b0, CFG_PAGE, CFG_REG, 16'h0000, d);
    chk({16'h0, d}, {23'h0, THR_RESET, RETRY_RESET}, "cfg reset");
  endtask : chk_rst

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    logic [15:0] d;
    int          n;
    {defer_event, defer_ipg_stream, mgmt_rd, mgmt_wr} = 4'h0;
    mgmt_page  = 10'h000;
    mgmt_addr  = 5'h00;
    mgmt_wdata = 16'h0000;
    foreach (exp_cnt[k]) exp_cnt[k] = STAT_RESET;
    void'($urandom(32'hD030));
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk_rst();
    frame(16, 0, 1, 1, 1, 1);
    set_thr(8'h10, d);
    frame(16, 0, 1, 0, 1, 1);
    frame(2, 0, 1, 1, 1, 0);
    frame(2, 0, 1, 1, 0, 1);
    frame(0, 1, 0, 1, 1, 1);
    frame(0, 0, 1, 1, 1, 1);
    frame(15, 0, 1, 1, 1, 1);
    acc(1'b1, STAT_PAGE, STAT_BASE[0], 16'hFFFF, d);
    acc(1'b0, STAT_PAGE, 5'h16, 16'h0000, d);
    chk({16'h0, d}, 32'h0, "unmapped");
    defer(1, 0);
    defer(1, 1);
    defer(0, 0);
    repeat (40) begin
      n = $urandom_range(16, 0);
      frame(n, n < 3 && $urandom_range(3, 0) == 0, 1'($urandom),
            1'($urandom), $urandom_range(3, 0) != 0,
            $urandom_range(3, 0) != 0);
      defer(1'($urandom), 1'($urandom));
      if ($urandom_range(7, 0) == 0) set_thr(8'($urandom_range(24, 8)), d);
    end
    chk_all();
    // a reset in mid-run must clear every count and the settings
    @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk_rst();
    frame(1, 0, 1, 1, 1, 1);
    conclude();
  end
  // the run needs about 0.5 ms; ten times that means a hang
  initial begin
    #5_000_000;
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tx_collision_statistics_tb_top
`default_nettype wire
